/* rtl/mmd_memory_map_decoder.sv */
`default_nettype none
// What this block does
// - 256 registers, sixteen groups by upper nibble
// - bank select gives fifteen extended banks
// - only group 0 of banks F, D
// - 32 extended slots, 21 implemented
// - group F holds control and status
// - group 0 low half ports, high RAM
// - groups 1 to E plus 0 upper RAM
// - 256-byte executable RAM at FF00-FFFF
// - program_space_load writes reach executable RAM
// - six 16-bit vectors at 0 to 11
// - vector upper byte even, lower odd
// - rom starts at 0C after vectors
// - every reset fetches first from 000C
// - rom top set by product variant
// - 8000 to FEFF has no memory
// - no external memory path at all
// - pairs: high byte even, low odd
module mmd_memory_map_decoder
  import mmd_pkg::*;
(
  input  wire logic          sys_clk,
  input  wire logic          arst_n,
  input  wire logic          wdt_reset,      // watchdog time-out, one-cycle pulse
  input  wire logic          stop_recover,   // stop-mode recovery, one-cycle pulse
  input  wire mmd_variant_t  variant,
  input  wire mmd_reg_req_t  reg_req,
  input  wire mmd_prog_req_t prog_req,
  input  wire logic [7:0]    rom_wr_data,    // rom image load port
  input  wire logic [13:0]   rom_wr_addr,
  input  wire logic          rom_wr_en,
  input  wire logic [7:0]    port_rd_data,   // io port register read value
  input  wire logic [7:0]    ctrl_rd_data,   // group F and extended register read value
  output logic [15:0]        reg_rdata,
  output logic               reg_rvalid,
  output logic [7:0]         port_sel,       // one-hot io port register select
  output logic               port_wr,
  output logic               ctrl_sel,
  output logic               ctrl_wr,
  output logic [4:0]         ext_slot,       // {bank is F, register}
  output logic [7:0]         ctrl_addr,
  output logic [7:0]         ctrl_wdata,
  output logic [7:0]         prog_rdata,
  output logic               prog_rvalid,
  output logic               prog_unimpl,
  output logic [15:0]        fetch_pc,       // next fetch address after reset
  output logic               boot_fetch
);

  // storage arrays; general RAM covers all 256 slots, only gp ones are used
  logic [7:0] gp_ram   [REG_SPACE];
  logic [7:0] xram     [XRAM_BYTES];
  logic [7:0] rom      [ROM_BYTES];

  // register-space classification, used for both bytes of a pair
  function automatic mmd_rreg_t reg_class(input logic [3:0] bank, input logic [7:0] a);
    logic [3:0] grp;
    logic [3:0] r;
    grp = a[7:4];
    r   = a[3:0];
    if (bank == BANK_STD) begin
      if (grp == GRP_CTRL)                    reg_class = MMD_RR_CTRL;
      else if (grp == GRP_IO && r <= IO_LAST_REG) reg_class = MMD_RR_IO;
      else                                    reg_class = MMD_RR_GP;
    end else if ((bank == BANK_EXT_F || bank == BANK_EXT_D) && grp == GRP_IO) begin
      if (EXT_IMPL_MASK[{bank == BANK_EXT_F, r}]) reg_class = MMD_RR_EXT;
      else                                    reg_class = MMD_RR_NONE;
    end else begin
      reg_class = MMD_RR_NONE;
    end
  endfunction

  // pair addresses: even byte is the high byte
  logic [7:0] addr_hi;
  logic [7:0] addr_lo;
  mmd_rreg_t  cls_hi;
  mmd_rreg_t  cls_lo;

  always_comb begin
    addr_hi = reg_req.pair ? {reg_req.addr[7:1], 1'b0} : reg_req.addr;
    addr_lo = {reg_req.addr[7:1], 1'b1};
    cls_hi  = reg_class(reg_req.bank, addr_hi);
    cls_lo  = reg_class(reg_req.bank, addr_lo);
  end

  // peripheral strobes; pairs to ports/ctrl use the even byte only
  always_comb begin
    port_sel   = ZERO_BYTE;
    port_wr    = 1'b0;
    ctrl_sel   = 1'b0;
    ctrl_wr    = 1'b0;
    ext_slot   = {reg_req.bank == BANK_EXT_F, addr_hi[3:0]};
    ctrl_addr  = addr_hi;
    ctrl_wdata = reg_req.pair ? reg_req.wdata[15:8] : reg_req.wdata[7:0];
    if (reg_req.rd || reg_req.wr) begin
      if (cls_hi == MMD_RR_IO) begin
        port_sel[addr_hi[2:0]] = 1'b1;
        port_wr = reg_req.wr;
      end
      if (cls_hi == MMD_RR_CTRL || cls_hi == MMD_RR_EXT) begin
        ctrl_sel = 1'b1;
        ctrl_wr  = reg_req.wr;
      end
    end
  end

  // general RAM write; other classes never touch the array
  always_ff @(posedge sys_clk) begin
    if (reg_req.wr && cls_hi == MMD_RR_GP) begin
      gp_ram[addr_hi] <= reg_req.pair ? reg_req.wdata[15:8] : reg_req.wdata[7:0];
    end
    if (reg_req.wr && reg_req.pair && cls_lo == MMD_RR_GP) begin
      gp_ram[addr_lo] <= reg_req.wdata[7:0];
    end
  end

  // byte read per class; unimplemented returns the fixed value
  function automatic logic [7:0] byte_read(input mmd_rreg_t c, input logic [7:0] ram_v,
                                           input logic [7:0] port_v, input logic [7:0] ctl_v);
    case (c)
      MMD_RR_GP:   byte_read = ram_v;
      MMD_RR_IO:   byte_read = port_v;
      MMD_RR_CTRL: byte_read = ctl_v;
      MMD_RR_EXT:  byte_read = ctl_v;
      default:     byte_read = UNIMPL_VAL;
    endcase
  endfunction

  // register read data, registered; low byte of a pair from ctrl reads fixed value
  // since the core sees only one peripheral byte per cycle
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  logic        rvalid_ff;
  logic        nxt_rvalid;
  logic [7:0]  lo_byte;
  logic [7:0]  hi_byte;

  always_comb begin
    hi_byte = byte_read(cls_hi, gp_ram[addr_hi], port_rd_data, ctrl_rd_data);
    lo_byte = (cls_lo == MMD_RR_GP) ? gp_ram[addr_lo] : UNIMPL_VAL;
    nxt_rvalid = reg_req.rd;
    nxt_rdata  = rdata_ff;
    if (reg_req.rd) begin
      nxt_rdata = reg_req.pair ? {hi_byte, lo_byte} : {ZERO_BYTE, hi_byte};
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff  <= 16'h0000;
      rvalid_ff <= 1'b0;
    end else begin
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  assign reg_rdata  = rdata_ff;
  assign reg_rvalid = rvalid_ff;

  // program space decode
  mmd_preg_t   p_region;
  mmd_prog_decode u_prog_decode (
    .addr    (prog_req.addr),
    .variant (variant),
    .region  (p_region)
  );

  // executable RAM takes program_space_load writes; rom and hole ignore them
  always_ff @(posedge sys_clk) begin
    if (prog_req.wr && p_region == MMD_PR_XRAM) begin
      xram[prog_req.addr[7:0]] <= prog_req.wdata;
    end
    if (rom_wr_en) begin
      rom[rom_wr_addr] <= rom_wr_data;                        // image load only
    end
  end

  // program read; vector bytes live in rom, upper byte at the even address
  logic [7:0] prdata_ff;
  logic [7:0] nxt_prdata;
  logic       prvalid_ff;
  logic       nxt_prvalid;
  logic       punimpl_ff;
  logic       nxt_punimpl;
  logic       prd;

  always_comb begin
    prd         = prog_req.rd || prog_req.fetch;
    nxt_prvalid = prd;
    nxt_prdata  = prdata_ff;
    nxt_punimpl = punimpl_ff;
    if (prd) begin
      nxt_punimpl = 1'b0;
      case (p_region)
        MMD_PR_VEC:  nxt_prdata = rom[prog_req.addr[13:0]];
        MMD_PR_ROM:  nxt_prdata = rom[prog_req.addr[13:0]];
        MMD_PR_XRAM: nxt_prdata = xram[prog_req.addr[7:0]];
        default: begin
          nxt_prdata  = UNIMPL_VAL;
          nxt_punimpl = 1'b1;
        end
      endcase
    end else if (prog_req.wr) begin
      nxt_punimpl = (p_region != MMD_PR_XRAM);
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_ff  <= ZERO_BYTE;
      prvalid_ff <= 1'b0;
      punimpl_ff <= 1'b0;
    end else begin
      prdata_ff  <= nxt_prdata;
      prvalid_ff <= nxt_prvalid;
      punimpl_ff <= nxt_punimpl;
    end
  end

  assign prog_rdata  = prdata_ff;
  assign prog_rvalid = prvalid_ff;
  assign prog_unimpl = punimpl_ff;

  // boot vector: any reset kind forces the first fetch to the rom base
  logic [15:0] pc_ff;
  logic [15:0] nxt_pc;
  logic        boot_ff;
  logic        nxt_boot;

  always_comb begin
    nxt_pc   = pc_ff;
    nxt_boot = 1'b0;
    if (wdt_reset || stop_recover) begin
      nxt_pc   = RESET_PC;
      nxt_boot = 1'b1;
    end else if (boot_ff && prog_req.fetch) begin
      nxt_boot = 1'b0;
    end else begin
      nxt_boot = boot_ff;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pc_ff   <= RESET_PC;
      boot_ff <= 1'b1;
    end else begin
      pc_ff   <= nxt_pc;
      boot_ff <= nxt_boot;
    end
  end

  assign fetch_pc   = pc_ff;
  assign boot_fetch = boot_ff;

endmodule
`default_nettype wire

/* rtl/mmd_pkg.sv */
`default_nettype none
package mmd_pkg;
  // standard register file geometry
  localparam int unsigned REG_SPACE   = 256;
  localparam int unsigned GROUP_CNT   = 16;
  localparam int unsigned GROUP_SIZE  = 16;
  localparam logic [3:0]  GRP_IO      = 4'h0;
  localparam logic [3:0]  GRP_CTRL    = 4'hF;
  localparam logic [3:0]  IO_LAST_REG = 4'h7;
  localparam int unsigned GP_BYTES    = 233;
  // extended banks
  localparam int unsigned BANK_CNT    = 16;
  localparam logic [3:0]  BANK_STD    = 4'h0;
  localparam logic [3:0]  BANK_EXT_D  = 4'hD;
  localparam logic [3:0]  BANK_EXT_F  = 4'hF;
  localparam int unsigned EXT_SLOTS   = 32;
  localparam int unsigned EXT_IMPL    = 21;
  // implemented extended slot mask: bit i of slot index {bank_is_f, reg}
  localparam logic [31:0] EXT_IMPL_MASK = 32'h001F_FFFF;
  // program space
  localparam logic [15:0] VEC_BASE    = 16'h0000;
  localparam logic [15:0] VEC_LAST    = 16'h000B;
  localparam logic [15:0] ROM_BASE    = 16'h000C;
  localparam logic [15:0] RESET_PC    = 16'h000C;
  localparam logic [15:0] ROM_TOP_S   = 16'h0FFF;
  localparam logic [15:0] ROM_TOP_M   = 16'h1FFF;
  localparam logic [15:0] ROM_TOP_L   = 16'h3FFF;
  localparam logic [15:0] HOLE_BASE   = 16'h8000;
  localparam logic [15:0] HOLE_TOP    = 16'hFEFF;
  localparam logic [15:0] XRAM_BASE   = 16'hFF00;
  localparam int unsigned XRAM_BYTES  = 256;
  localparam int unsigned ROM_BYTES   = 16384;
  localparam logic [7:0]  UNIMPL_VAL  = 8'hFF;
  localparam logic [7:0]  ZERO_BYTE   = 8'h00;

  typedef enum logic [1:0] {MMD_VAR_SMALL, MMD_VAR_MID, MMD_VAR_LARGE} mmd_variant_t;
  typedef enum {MMD_PR_VEC, MMD_PR_ROM, MMD_PR_XRAM, MMD_PR_NONE} mmd_preg_t;
  typedef enum {MMD_RR_IO, MMD_RR_GP, MMD_RR_CTRL, MMD_RR_EXT, MMD_RR_NONE} mmd_rreg_t;

  // register-file access from the core
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       pair;   // 16-bit even/odd access
    logic [3:0] bank;
    logic [7:0] addr;
    logic [15:0] wdata;
  } mmd_reg_req_t;

  // program-space access from the core
  typedef struct packed {
    logic        fetch;
    logic        rd;
    logic        wr;     // program_space_load write
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mmd_prog_req_t;
endpackage
`default_nettype wire

/* rtl/mmd_prog_decode.sv */
`default_nettype none
// classifies a program address into its region
module mmd_prog_decode
  import mmd_pkg::*;
(
  input  wire logic [15:0]  addr,
  input  wire mmd_variant_t variant,
  output mmd_preg_t         region
);
  logic [15:0] rom_top;

  // rom top follows the product variant
  always_comb begin
    case (variant)
      MMD_VAR_SMALL: rom_top = ROM_TOP_S;
      MMD_VAR_MID:   rom_top = ROM_TOP_M;
      MMD_VAR_LARGE: rom_top = ROM_TOP_L;
      default:       rom_top = ROM_TOP_S;
    endcase
  end

  // region decode; hole and gap above rom top are unbacked
  always_comb begin
    if (addr <= VEC_LAST) begin
      region = MMD_PR_VEC;
    end else if (addr >= ROM_BASE && addr <= rom_top) begin
      region = MMD_PR_ROM;
    end else if (addr >= XRAM_BASE) begin
      region = MMD_PR_XRAM;
    end else begin
      region = MMD_PR_NONE;
    end
  end
endmodule
`default_nettype wire

/* verif/mmd_memory_map_decoder_props.sv */
`default_nettype none
module mmd_memory_map_decoder_props
  import mmd_pkg::*;
(
  input wire logic          sys_clk,
  input wire logic          arst_n,
  input wire logic          wdt_reset,
  input wire logic          stop_recover,
  input wire mmd_reg_req_t  reg_req,
  input wire mmd_prog_req_t prog_req,
  input wire logic [15:0]   reg_rdata,
  input wire logic          reg_rvalid,
  input wire logic [7:0]    port_sel,
  input wire logic          port_wr,
  input wire logic          ctrl_sel,
  input wire logic          ctrl_wr,
  input wire logic [4:0]    ext_slot,
  input wire logic [7:0]    ctrl_wdata,
  input wire logic [7:0]    prog_rdata,
  input wire logic          prog_rvalid,
  input wire logic          prog_unimpl,
  input wire logic [15:0]   fetch_pc,
  input wire logic          boot_fetch
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // standard bank read, the common antecedent
  wire std_rd = reg_req.rd && reg_req.bank == 4'h0;
  // single-byte standard bank write; a pair would steer by its even byte
  wire std_wr = reg_req.wr && !reg_req.pair && reg_req.bank == 4'h0;

  a_reg_answer: assert property (reg_req.rd |=> reg_rvalid)
    else $error("register read not answered");
  a_port_onehot: assert property (std_rd && reg_req.addr[7:3] == 5'h00
    |-> port_sel == (8'h01 << {reg_req.addr[2:1], reg_req.addr[0] & !reg_req.pair}))
    else $error("wrong port select");
  a_port_write: assert property (std_wr && reg_req.addr[7:3] == 5'h00
    |-> port_wr && port_sel == (8'h01 << reg_req.addr[2:0]))
    else $error("port write not steered");
  a_ctrl_group: assert property (std_rd && reg_req.addr[7:4] == 4'hF |-> ctrl_sel)
    else $error("group F not control");
  a_ctrl_write: assert property (std_wr && reg_req.addr[7:4] == 4'hF
    |-> ctrl_wr && ctrl_wdata == reg_req.wdata[7:0])
    else $error("control write not steered");
  a_ext_slot: assert property (reg_req.rd && !reg_req.pair && reg_req.bank == 4'hF
    && reg_req.addr[7:4] == 4'h0 |-> ext_slot == {1'b1, reg_req.addr[3:0]} && ctrl_sel == (reg_req.addr[3:0] < 4'h5))
    else $error("extended slot mis-decoded");
  a_gp_private: assert property (std_rd && reg_req.addr[7:4] inside {[4'h1:4'hE]}
    |-> !ctrl_sel && port_sel == 8'h00)
    else $error("ram group leaked a select");
  a_bank_absent: assert property (reg_req.rd && !reg_req.pair && !(reg_req.bank inside {4'h0, 4'hD, 4'hF})
    |=> reg_rdata == 16'h00FF)
    else $error("absent bank read not FF");
  a_prog_answer: assert property (prog_req.rd || prog_req.fetch |=> prog_rvalid)
    else $error("program read not answered");
  a_hole_empty: assert property (prog_req.rd && prog_req.addr inside {[16'h8000:16'hFEFF]}
    |=> prog_unimpl && prog_rdata == 8'hFF)
    else $error("hole read returned data");
  a_xram_backed: assert property (prog_req.rd && prog_req.addr >= 16'hFF00 |=> !prog_unimpl)
    else $error("executable ram flagged unbacked");
  a_rom_locked: assert property (prog_req.wr && prog_req.addr < 16'hFF00 |=> prog_unimpl)
    else $error("rom write not refused");
  a_boot_vector: assert property (wdt_reset || stop_recover |=> boot_fetch && fetch_pc == 16'h000C)
    else $error("restart did not aim at 000C");

  c_pair_read: cover property (reg_req.rd && reg_req.pair);
  c_xram_wr_rd: cover property (prog_req.wr ##1 !prog_req.wr [*1] ##1 prog_req.rd);
  c_stop_boot: cover property (stop_recover ##1 boot_fetch);
endmodule

bind mmd_memory_map_decoder mmd_memory_map_decoder_props i_props (.sys_clk(sys_clk), .arst_n(arst_n),
  .wdt_reset(wdt_reset), .stop_recover(stop_recover), .reg_req(reg_req), .prog_req(prog_req),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .port_sel(port_sel), .port_wr(port_wr), .ctrl_sel(ctrl_sel),
  .ctrl_wr(ctrl_wr), .ext_slot(ext_slot), .ctrl_wdata(ctrl_wdata),
  .prog_rdata(prog_rdata), .prog_rvalid(prog_rvalid), .prog_unimpl(prog_unimpl), .fetch_pc(fetch_pc),
  .boot_fetch(boot_fetch));
`default_nettype wire

/* verif/mmd_memory_map_decoder_test.sv */
`default_nettype none
module mmd_memory_map_decoder_test
  import mmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, arst_n, wdt_reset, stop_recover, rom_wr_en, reg_rvalid, prog_rvalid, prog_unimpl, boot_fetch;
  mmd_variant_t  variant;
  mmd_reg_req_t  reg_req;
  mmd_prog_req_t prog_req;
  logic [7:0]    rom_wr_data, port_rd_data, ctrl_rd_data, port_sel, ctrl_addr, prog_rdata;
  logic [13:0]   rom_wr_addr;
  logic [15:0]   reg_rdata, fetch_pc;
  logic [7:0]    pm [65536];
  int            bad_count, n_tests;

  mmd_memory_map_decoder i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .wdt_reset(wdt_reset),
    .stop_recover(stop_recover), .variant(variant), .reg_req(reg_req), .prog_req(prog_req),
    .rom_wr_data(rom_wr_data), .rom_wr_addr(rom_wr_addr), .rom_wr_en(rom_wr_en), .port_rd_data(port_rd_data),
    .ctrl_rd_data(ctrl_rd_data), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .port_sel(port_sel),
    .port_wr(), .ctrl_sel(), .ctrl_wr(), .ext_slot(), .ctrl_addr(ctrl_addr), .ctrl_wdata(),
    .prog_rdata(prog_rdata), .prog_rvalid(prog_rvalid), .prog_unimpl(prog_unimpl), .fetch_pc(fetch_pc),
    .boot_fetch(boot_fetch));
  mmd_periph_model i_periph (.port_sel(port_sel), .ctrl_addr(ctrl_addr), .port_rd_data(port_rd_data),
    .ctrl_rd_data(ctrl_rd_data));

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one-cycle request, result looked at once the answering edge has landed
  task automatic rop(input logic rd, input logic wr, input logic pr, input logic [3:0] bk,
                     input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_req <= '{rd: rd, wr: wr, pair: pr, bank: bk, addr: a, wdata: d};
    @(posedge sys_clk);
    reg_req <= '0;
    #1;
  endtask
  task automatic pop(input logic f, input logic rd, input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    prog_req <= '{fetch: f, rd: rd, wr: wr, addr: a, wdata: d};
    @(posedge sys_clk);
    prog_req <= '0;
    #1;
  endtask
  // backed program addresses: rom up to the variant's top, and executable ram
  function automatic logic pback(input logic [15:0] a);
    logic [15:0] top;
    top = variant == MMD_VAR_SMALL ? 16'h0FFF : variant == MMD_VAR_MID ? 16'h1FFF : 16'h3FFF;
    return a <= top || a >= 16'hFF00;
  endfunction
  task automatic pchk(input logic [15:0] a);
    pop(1'b0, 1'b1, 1'b0, a, 8'h00);
    chk("prog_rdata", {8'h00, pback(a) ? pm[a] : 8'hFF}, {8'h00, prog_rdata});
    chk("prog_unimpl", {15'h0, !pback(a)}, {15'h0, prog_unimpl});
  endtask
  task automatic print_verdict;
    if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  initial begin
    logic [7:0] a, d, rf [256];
    logic [15:0] ra [21], w;
    {arst_n, wdt_reset, stop_recover, rom_wr_en, rom_wr_data, rom_wr_addr} = '0;
    reg_req = '0;
    prog_req = '0;
    variant = MMD_VAR_SMALL;
    bad_count = 0;
    n_tests = 0;
    ra = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 16'h0FFF, 16'h1000, 16'h1FFF, 16'h2000, 16'h3FFF, 16'h4000};
    void'($urandom(32'h17D3));
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    #1;
    chk("boot_pc", 16'h000C, fetch_pc);
    // rom image: vectors, first rom bytes and every variant boundary
    foreach (ra[k]) begin
      @(posedge sys_clk);
      d = 8'($urandom);
      rom_wr_en <= ra[k] < 16'h4000;  // past the array would alias onto the vectors
      rom_wr_addr <= ra[k][13:0];
      rom_wr_data <= d;
      pm[ra[k]] = d;
    end
    @(posedge sys_clk);
    rom_wr_en <= 1'b0;
    pop(1'b1, 1'b0, 1'b0, 16'h000C, 8'h00);
    chk("boot_fetch", 16'h0000, {15'h0, boot_fetch});
    chk("first_op", {8'h00, pm[12]}, {8'h00, prog_rdata});
    for (int v = 0; v < 3; v++) begin
      @(posedge sys_clk);
      variant <= mmd_variant_t'(v);
      foreach (ra[k]) pchk(ra[k]);
    end
    foreach (ra[k]) pchk(16'h8000 + 16'($urandom_range(0, 16'h7EFF)));
    pchk(16'h8000);
    pchk(16'hFEFF);
    for (int i = 0; i < 10; i++) begin
      w = i == 0 ? 16'hFF00 : i == 1 ? 16'hFFFF : 16'hFF00 | 16'($urandom_range(0, 255));
      pm[w] = 8'($urandom);
      pop(1'b0, 1'b0, 1'b1, w, pm[w]);
      pchk(w);
    end
    pop(1'b0, 1'b0, 1'b1, 16'h000C, ~pm[12]);
    chk("rom_wr_refused", 16'h0001, {15'h0, prog_unimpl});
    pchk(16'h000C);
    // general storage: group 0 upper half through group E, both ends included
    for (int i = 0; i < 30; i++) begin
      a = i == 0 ? 8'h08 : i == 1 ? 8'hEF : i == 2 ? 8'h20 : 8'h08 + 8'($urandom_range(0, 231));
      rf[a] = 8'($urandom);
      rop(1'b0, 1'b1, 1'b0, 4'h0, a, {8'h00, rf[a]});
      rop(1'b1, 1'b0, 1'b0, 4'h0, a, 16'h0000);
      chk("gp_ram", {8'h00, rf[a]}, reg_rdata);
    end
    a = 8'h10 + {3'($urandom_range(0, 6)), 5'h0} + 8'h0E;
    w = 16'($urandom);
    rop(1'b0, 1'b1, 1'b1, 4'h0, a, w);
    rop(1'b1, 1'b0, 1'b1, 4'h0, a, 16'h0000);
    chk("pair", w, reg_rdata);
    rop(1'b1, 1'b0, 1'b0, 4'h0, a | 8'h01, 16'h0000);
    chk("pair_low", {8'h00, w[7:0]}, reg_rdata);
    for (int i = 0; i < 8; i++) begin
      rop(1'b1, 1'b0, 1'b0, 4'h0, 8'(i), 16'h0000);
      chk("port", {8'h00, ~(8'h01 << i)}, reg_rdata);
    end
    rop(1'b0, 1'b1, 1'b0, 4'h0, 8'h03, 16'h00A5);
    rop(1'b0, 1'b1, 1'b0, 4'h0, 8'hF5, 16'h003C);
    for (int i = 0; i < 48; i++) begin
      a = i < 16 ? 8'hF0 | 8'(i) : 8'(i % 16);
      rop(1'b1, 1'b0, 1'b0, i < 16 ? 4'h0 : i < 32 ? 4'hD : 4'hF, a, 16'h0000);
      chk("ctrl", {8'h00, (i < 37) ? a ^ 8'h5A : 8'hFF}, reg_rdata);
    end
    for (int b = 1; b < 15; b++) begin
      a = 8'($urandom);
      rop(1'b1, 1'b0, 1'b0, 4'(b), a, 16'h0000);
      chk("absent", (b == 13 && a[7:4] == 4'h0) ? {8'h00, a ^ 8'h5A} : 16'h00FF, reg_rdata);
    end
    rop(1'b1, 1'b0, 1'b0, 4'hD, 8'h30, 16'h0000);
    chk("ext_group", 16'h00FF, reg_rdata);
    rop(1'b0, 1'b1, 1'b0, 4'h5, 8'h20, ~{8'h00, rf[8'h20]});
    rop(1'b1, 1'b0, 1'b0, 4'h0, 8'h20, 16'h0000);
    chk("undisturbed", {8'h00, rf[8'h20]}, reg_rdata);
    // both restart sources must send the core back to the first rom byte
    for (int s = 0; s < 2; s++) begin
      pop(1'b1, 1'b0, 1'b0, 16'h0040, 8'h00);
      @(posedge sys_clk);
      {wdt_reset, stop_recover} <= s == 0 ? 2'b10 : 2'b01;
      @(posedge sys_clk);
      {wdt_reset, stop_recover} <= 2'b00;
      #1;
      chk("restart_pc", 16'h000C, fetch_pc);
      chk("restart_boot", 16'h0001, {15'h0, boot_fetch});
    end
    print_verdict();
  end
endmodule
`default_nettype wire

/* verif/mmd_periph_model.sv */
`default_nettype none
// far side: port and control registers answer with patterns the bench can predict
module mmd_periph_model (
  input  wire logic [7:0] port_sel,
  input  wire logic [7:0] ctrl_addr,
  output logic [7:0]      port_rd_data,
  output logic [7:0]      ctrl_rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // inverted select, so a wrong or doubled select shows as a wrong byte
  assign port_rd_data = ~port_sel;
  assign ctrl_rd_data = ctrl_addr ^ 8'h5A;
endmodule
`default_nettype wire
